//--- bench/ddrtc_ctrl_tb.sv
// self-checking bench: pin codes, spacing, refresh debt, sleep exits
`timescale 1ns/1ps
module ddrtc_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0;
    ddrtc_pkg::ddrtc_op_t op = ddrtc_pkg::OP_NOP;
    logic [1:0] bnk = 2'h0;
    logic ap = 1'b0;
    logic wlast = 1'b0;
    logic unst = 1'b0;
    logic hot = 1'b0;
    logic ack, due, urg, cke, ras_n, cas_n, we_n, a_ap, dqs_o, dqs_oe;
    logic [1:0] ba;
    logic [7:0] errs;
    logic [7:0] expq[$];
    logic [7:0] e;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int t0, t1, tw;
    int seed = 32'h9a5f;
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ddrtc_ctrl uut (.i_clk_sys(clk), .i_resetn(rst_n), .i_cmd_valid(vld), .i_cmd_op(op),
        .i_cmd_bank(bnk), .i_cmd_ap(ap), .o_cmd_ack(ack), .i_wdata_last(wlast),
        .i_hot_temp(hot), .i_clk_unstable(unst), .o_refresh_due(due),
        .o_refresh_urgent(urg), .o_cke(cke), .o_ras_n(ras_n), .o_cas_n(cas_n),
        .o_we_n(we_n), .o_ba(ba), .o_a_ap(a_ap), .o_dqs_o(dqs_o), .o_dqs_oe(dqs_oe));
    ddrtc_mem_model mem (.i_clk_sys(clk), .i_resetn(rst_n), .i_cke(cke),
        .i_cmd({ras_n, cas_n, we_n}), .i_dqs_o(dqs_o), .i_dqs_oe(dqs_oe), .o_errs(errs));
    task automatic check_pins(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t pins got %h exp %h", $time, got, exp);
        end
    endtask : check_pins
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t flag got %h exp %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // holds the request until acked; notes the expected pins for the monitor
    task automatic issue(input ddrtc_pkg::ddrtc_op_t o, input logic [1:0] b, input logic a,
            output int t);
        logic [2:0] p;
        int n;
        case (o)
            ddrtc_pkg::OP_ACT: p = ddrtc_pkg::PINS_ACT;
            ddrtc_pkg::OP_READ: p = ddrtc_pkg::PINS_READ;
            ddrtc_pkg::OP_WRITE: p = ddrtc_pkg::PINS_WRITE;
            ddrtc_pkg::OP_PRE: p = ddrtc_pkg::PINS_PRE;
            ddrtc_pkg::OP_REF: p = ddrtc_pkg::PINS_REF;
            default: p = 3'h0;
        endcase
        n = 0;
        @(posedge clk);
        expq.push_back({p != 3'h0, p, o == ddrtc_pkg::OP_WRITE, a, b});
        vld <= 1'b1;
        op <= o;
        bnk <= b;
        ap <= a;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 400);
        vld <= 1'b0;
        t = cyc;
        if (n >= 400) check_bit(1'b0, 1'b1);
    endtask : issue
    task automatic wpulse(output int t);
        @(posedge clk);
        wlast <= 1'b1;
        @(posedge clk);
        wlast <= 1'b0;
        t = cyc;
    endtask : wpulse
    always @(posedge clk) begin
        if (ack === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[7]) check_pins({ras_n, cas_n, we_n, dqs_oe, a_ap, ba}, e[6:0]);
        end
    end
    initial begin
        repeat (10000) @(posedge clk);
        check_bit(1'b0, 1'b1);
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (1570) @(posedge clk);
        check_bit(urg, 1'b1);
        repeat (230) @(posedge clk);
        repeat (8) issue(ddrtc_pkg::OP_REF, 2'h0, 1'b0, t0);
        repeat (2) @(posedge clk);
        check_bit(due, 1'b0);
        $display("test refresh debt done");
        repeat (8) begin
            bnk <= 2'($random(seed));
            @(posedge clk);
            issue(ddrtc_pkg::OP_ACT, bnk, 1'b0, t0);
            issue(($random(seed) % 2) ? ddrtc_pkg::OP_WRITE : ddrtc_pkg::OP_READ,
                bnk, 1'b0, t0);
            if (op == ddrtc_pkg::OP_WRITE) wpulse(tw);
            issue(ddrtc_pkg::OP_PRE, bnk, 1'b0, t0);
        end
        $display("test random bank traffic done");
        for (int k = 0; k < 2; k++) begin
            issue(ddrtc_pkg::OP_ACT, 2'h1, 1'b0, t0);
            issue(ddrtc_pkg::OP_WRITE, 2'h1, k[0], t0);
            wpulse(tw);
            issue(k ? ddrtc_pkg::OP_ACT : ddrtc_pkg::OP_READ, 2'h1, 1'b0, t1);
            check_bit(t1 - tw >= 3, 1'b1);
            issue(ddrtc_pkg::OP_PRE, 2'h1, 1'b0, t1);
        end
        $display("test write turnaround done");
        for (int k = 0; k < 2; k++) begin
            unst <= 1'b1;
            issue(k ? ddrtc_pkg::OP_PD_IN : ddrtc_pkg::OP_SREF_IN, 2'h0, 1'b0, t0);
            check_bit(cke, 1'b0);
            issue(k ? ddrtc_pkg::OP_PD_OUT : ddrtc_pkg::OP_SREF_OUT, 2'h0, 1'b0, t0);
            check_bit(cke, 1'b1);
            unst <= 1'b0;
            issue(ddrtc_pkg::OP_ACT, 2'h3, 1'b0, t1);
            issue(ddrtc_pkg::OP_READ, 2'h3, 1'b0, t1);
            check_bit(t1 - t0 >= 200, 1'b1);
            issue(ddrtc_pkg::OP_PRE, 2'h3, 1'b0, t1);
        end
        $display("test sleep exits done");
        hot <= 1'b1;
        repeat (600) @(posedge clk);
        check_bit(urg, 1'b1);
        $display("test hot refresh interval done");
        repeat (4) @(posedge clk);
        check_bit(errs === 8'h00, 1'b1);
        print_verdict();
    end
endmodule : ddrtc_ctrl_tb

//--- bench/ddrtc_mem_model.sv
// memory-side model: counts spacing and strobe faults seen on the pins
`timescale 1ns/1ps
module ddrtc_mem_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // memory pins
    input wire logic i_cke,
    input wire logic [2:0] i_cmd,
    input wire logic i_dqs_o,
    input wire logic i_dqs_oe,
    // faults seen
    output logic [7:0] o_errs
);
    int cyc;
    int last_t;
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cyc = 0;
            last_t = -9;
            o_errs <= 8'h00;
        end else begin
            cyc = cyc + 1;
            if (i_cke && (i_cmd == ddrtc_pkg::PINS_ACT || i_cmd == ddrtc_pkg::PINS_REF)) begin
                if (cyc - last_t < 2) begin
                    o_errs <= o_errs + 8'h01;
                end
                last_t = cyc;
            end
            if (i_cmd == ddrtc_pkg::PINS_WRITE && !(i_dqs_oe && !i_dqs_o)) begin
                o_errs <= o_errs + 8'h01;
            end
        end
    end
endmodule : ddrtc_mem_model

//--- inc/ddrtc_pkg.sv
// package: command set, pin encodings and timing figures for the ddr command timing checker
package ddrtc_pkg;

    // ------------------------------------------------------------
    // clock and conversion
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 40000;

    // least times round up, never below one cycle
    function automatic int unsigned ddrtc_cyc_min(input int unsigned ps);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : ddrtc_cyc_min

    // longest times round down, never below one cycle
    function automatic int unsigned ddrtc_cyc_max(input int unsigned ps);
        int unsigned c;
        c = ps / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : ddrtc_cyc_max

    // ------------------------------------------------------------
    // timing figures, -5 and -6 grades
    // ------------------------------------------------------------
    localparam int unsigned ACT_TO_ACT_PERIOD_NS_5 = 55;
    localparam int unsigned ACT_TO_ACT_PERIOD_NS_6 = 60;
    localparam int unsigned REFRESH_CYCLE_TIME_NS_5 = 70;
    localparam int unsigned REFRESH_CYCLE_TIME_NS_6 = 72;
    localparam int unsigned ACT_TO_RW_DELAY_NS = 15;
    localparam int unsigned PRECHARGE_PERIOD_NS = 15;
    localparam int unsigned WRITE_RECOVERY_NS = 15;
    localparam int unsigned BANK_TO_BANK_ACT_GAP_NS_5 = 10;
    localparam int unsigned BANK_TO_BANK_ACT_GAP_NS_6 = 12;
    localparam int unsigned WRITE_TO_READ_TURNAROUND_CK_5 = 2;
    localparam int unsigned WRITE_TO_READ_TURNAROUND_CK_6 = 1;
    localparam int unsigned SELFREF_EXIT_NONREAD_WAIT_NS_5 = 70;
    localparam int unsigned SELFREF_EXIT_NONREAD_WAIT_NS_6 = 75;
    localparam int unsigned SELFREF_EXIT_READ_WAIT_CK = 200;
    localparam int unsigned POWERDOWN_EXIT_READ_WAIT_CK = 200;
    localparam int unsigned REFRESH_INTERVAL_AVG_NS_NARROW = 7800;
    localparam int unsigned REFRESH_INTERVAL_AVG_NS_WIDE = 15600;
    localparam int unsigned REFRESH_INTERVAL_AVG_NS_NARROW_HOT = 1900;
    localparam int unsigned REFRESH_INTERVAL_AVG_NS_WIDE_HOT = 3900;
    localparam int unsigned PS_PER_NS = 1000;
    localparam int unsigned MAX_POSTED_REFRESH = 8;

    // ------------------------------------------------------------
    // sizes and pin encodings {ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam int unsigned NUM_BANKS = 4;
    localparam int unsigned TIMER_W = 8;
    localparam int unsigned REFI_W = 10;
    localparam int unsigned DEBT_W = 4;
    localparam logic [2:0] PINS_NOP = 3'h7;
    localparam logic [2:0] PINS_ACT = 3'h3;
    localparam logic [2:0] PINS_READ = 3'h5;
    localparam logic [2:0] PINS_WRITE = 3'h4;
    localparam logic [2:0] PINS_PRE = 3'h2;
    localparam logic [2:0] PINS_REF = 3'h1;
    localparam logic [TIMER_W-1:0] SINCE_MAX = 8'hff;

    typedef enum logic [3:0] {
        OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REF,
        OP_SREF_IN, OP_SREF_OUT, OP_PD_IN, OP_PD_OUT
    } ddrtc_op_t;

    typedef enum logic [1:0] {PW_AWAKE, PW_SREF, PW_PD} ddrtc_pwr_t;

endpackage : ddrtc_pkg

//--- logic/ddrtc_ctrl.sv
// module: host-side ddr command issuer that holds every command until its spacing is met
// ------------------------------------------------------------
// Notes on behaviour
// - activate to activate or refresh waits
// - refresh to activate or refresh waits
// - activate to read/write same bank waits
// - write recovery plus precharge after autoprecharge write
// - autoprecharge access waits after bank activate
// - activates to different banks spaced apart
// - last write data to read turnaround
// - self refresh exit to non-read waits
// - self refresh exit to read 200 cycles
// - refresh interval average kept only while awake, paused in self refresh and power-down, temperature aware
// - posted refresh debt saturates at eight
// - unstable clock power-down exit to read waits 200 cycles
// - write strobe driven low as preamble
// ------------------------------------------------------------
`timescale 1ns/1ps
module ddrtc_ctrl #(
    parameter bit GRADE_5 = 1'b1,
    parameter bit WIDE_X32 = 1'b0
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // command request
    input wire logic i_cmd_valid,
    input wire ddrtc_pkg::ddrtc_op_t i_cmd_op,
    input wire logic [1:0] i_cmd_bank,
    input wire logic i_cmd_ap,
    output logic o_cmd_ack,
    // write data and conditions
    input wire logic i_wdata_last,
    input wire logic i_hot_temp,
    input wire logic i_clk_unstable,
    // refresh status
    output logic o_refresh_due,
    output logic o_refresh_urgent,
    // memory pins
    output logic o_cke,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic [1:0] o_ba,
    output logic o_a_ap,
    output logic o_dqs_o,
    output logic o_dqs_oe
);
    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam int unsigned NSP = ddrtc_pkg::PS_PER_NS;
    localparam int unsigned RC = ddrtc_pkg::ddrtc_cyc_min(NSP * (GRADE_5 ?
        ddrtc_pkg::ACT_TO_ACT_PERIOD_NS_5 : ddrtc_pkg::ACT_TO_ACT_PERIOD_NS_6));
    localparam int unsigned RFC = ddrtc_pkg::ddrtc_cyc_min(NSP * (GRADE_5 ?
        ddrtc_pkg::REFRESH_CYCLE_TIME_NS_5 : ddrtc_pkg::REFRESH_CYCLE_TIME_NS_6));
    localparam int unsigned RCD = ddrtc_pkg::ddrtc_cyc_min(NSP * ddrtc_pkg::ACT_TO_RW_DELAY_NS);
    localparam int unsigned RP = ddrtc_pkg::ddrtc_cyc_min(NSP * ddrtc_pkg::PRECHARGE_PERIOD_NS);
    localparam int unsigned WR = ddrtc_pkg::ddrtc_cyc_min(NSP * ddrtc_pkg::WRITE_RECOVERY_NS);
    localparam int unsigned DAL = WR + RP;
    localparam int unsigned RRD = ddrtc_pkg::ddrtc_cyc_min(NSP * (GRADE_5 ?
        ddrtc_pkg::BANK_TO_BANK_ACT_GAP_NS_5 : ddrtc_pkg::BANK_TO_BANK_ACT_GAP_NS_6));
    localparam int unsigned WTR = GRADE_5 ? ddrtc_pkg::WRITE_TO_READ_TURNAROUND_CK_5 :
        ddrtc_pkg::WRITE_TO_READ_TURNAROUND_CK_6;
    localparam int unsigned XSNR = ddrtc_pkg::ddrtc_cyc_min(NSP * (GRADE_5 ?
        ddrtc_pkg::SELFREF_EXIT_NONREAD_WAIT_NS_5 : ddrtc_pkg::SELFREF_EXIT_NONREAD_WAIT_NS_6));
    localparam int unsigned XSRD = ddrtc_pkg::SELFREF_EXIT_READ_WAIT_CK;
    localparam int unsigned XPRD = ddrtc_pkg::POWERDOWN_EXIT_READ_WAIT_CK;
    localparam int unsigned REFI_COOL = ddrtc_pkg::ddrtc_cyc_max(NSP * (WIDE_X32 ?
        ddrtc_pkg::REFRESH_INTERVAL_AVG_NS_WIDE : ddrtc_pkg::REFRESH_INTERVAL_AVG_NS_NARROW));
    localparam int unsigned REFI_HOT = ddrtc_pkg::ddrtc_cyc_max(NSP * (WIDE_X32 ?
        ddrtc_pkg::REFRESH_INTERVAL_AVG_NS_WIDE_HOT :
        ddrtc_pkg::REFRESH_INTERVAL_AVG_NS_NARROW_HOT));
    localparam int unsigned NB = ddrtc_pkg::NUM_BANKS;
    localparam int unsigned TW = ddrtc_pkg::TIMER_W;
    localparam int unsigned DMAX = ddrtc_pkg::MAX_POSTED_REFRESH;

    // ------------------------------------------------------------
    // acceptance
    // ------------------------------------------------------------
    ddrtc_pkg::ddrtc_pwr_t pwr_q;
    ddrtc_pkg::ddrtc_op_t op_q;
    logic [NB-1:0] rc_done, rcd_done, pre_done, ap_pend_q, bsel;
    logic rrd_done, rfc_done, wtr_done, xsnr_done, rd_done;
    logic legal, take, awake, bank_ok;
    logic [ddrtc_pkg::DEBT_W-1:0] debt_q;
    logic [ddrtc_pkg::REFI_W-1:0] refi_q;
    logic wr_active_q;

    assign awake = (pwr_q == ddrtc_pkg::PW_AWAKE);
    assign bsel = NB'(1) << i_cmd_bank;
    assign bank_ok = pre_done[i_cmd_bank] && !ap_pend_q[i_cmd_bank];

    always_comb begin
        unique case (i_cmd_op)
            ddrtc_pkg::OP_ACT: legal = awake && xsnr_done && rfc_done && rrd_done
                && rc_done[i_cmd_bank] && bank_ok;
            ddrtc_pkg::OP_READ: legal = awake && rd_done && wtr_done
                && rcd_done[i_cmd_bank] && !ap_pend_q[i_cmd_bank];
            ddrtc_pkg::OP_WRITE: legal = awake && xsnr_done
                && rcd_done[i_cmd_bank] && !ap_pend_q[i_cmd_bank];
            ddrtc_pkg::OP_PRE: legal = awake && xsnr_done && !ap_pend_q[i_cmd_bank];
            ddrtc_pkg::OP_REF: legal = awake && xsnr_done && rfc_done
                && (&rc_done) && (&pre_done) && !(|ap_pend_q);
            ddrtc_pkg::OP_SREF_IN: legal = awake && xsnr_done && (&pre_done) && !(|ap_pend_q);
            ddrtc_pkg::OP_PD_IN: legal = awake && xsnr_done;
            ddrtc_pkg::OP_SREF_OUT: legal = (pwr_q == ddrtc_pkg::PW_SREF);
            ddrtc_pkg::OP_PD_OUT: legal = (pwr_q == ddrtc_pkg::PW_PD);
            default: legal = 1'b0;
        endcase
    end

    // one command per ack; the requester drops valid on ack
    assign take = i_cmd_valid && legal && !o_cmd_ack;

    // ------------------------------------------------------------
    // per-bank timers
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            logic act_b, pre_ld;
            logic [TW-1:0] pre_val;
            assign act_b = take && (i_cmd_op == ddrtc_pkg::OP_ACT) && bsel[b];
            // plain precharge (ap = all banks), read autoprecharge, or write autoprecharge end
            assign pre_ld = (take && (i_cmd_op == ddrtc_pkg::OP_PRE) && (bsel[b] || i_cmd_ap))
                || (take && (i_cmd_op == ddrtc_pkg::OP_READ) && i_cmd_ap && bsel[b])
                || (i_wdata_last && ap_pend_q[b]);
            assign pre_val = (i_wdata_last && ap_pend_q[b]) ? TW'(DAL) : TW'(RP);
            ddrtc_timer #(.W(TW)) u_rc (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
                .i_load(act_b), .i_value(TW'(RC)), .o_done(rc_done[b]));
            ddrtc_timer #(.W(TW)) u_rcd (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
                .i_load(act_b), .i_value(TW'(RCD)), .o_done(rcd_done[b]));
            ddrtc_timer #(.W(TW)) u_pre (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
                .i_load(pre_ld), .i_value(pre_val), .o_done(pre_done[b]));
        end
    endgenerate

    // bank blocked from autoprecharge write until write recovery starts
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ap_pend_q <= '0;
        end else begin
            for (int k = 0; k < NB; k++) begin
                if (take && (i_cmd_op == ddrtc_pkg::OP_WRITE) && i_cmd_ap && bsel[k]) begin
                    ap_pend_q[k] <= 1'b1;
                end else if (i_wdata_last) begin
                    ap_pend_q[k] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // shared timers
    // ------------------------------------------------------------
    logic srx, pdx;
    assign srx = take && (i_cmd_op == ddrtc_pkg::OP_SREF_OUT);
    assign pdx = take && (i_cmd_op == ddrtc_pkg::OP_PD_OUT) && i_clk_unstable;

    ddrtc_timer #(.W(TW)) u_rrd (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_load(take && (i_cmd_op == ddrtc_pkg::OP_ACT)), .i_value(TW'(RRD)),
        .o_done(rrd_done));
    ddrtc_timer #(.W(TW)) u_rfc (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_load(take && (i_cmd_op == ddrtc_pkg::OP_REF)), .i_value(TW'(RFC)),
        .o_done(rfc_done));
    ddrtc_timer #(.W(TW)) u_wtr (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_load(i_wdata_last), .i_value(TW'(WTR)), .o_done(wtr_done));
    ddrtc_timer #(.W(TW)) u_xsnr (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_load(srx), .i_value(TW'(XSNR)), .o_done(xsnr_done));
    ddrtc_timer #(.W(TW)) u_rd (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_load(srx || pdx), .i_value(srx ? TW'(XSRD) : TW'(XPRD)),
        .o_done(rd_done));

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pwr_q <= ddrtc_pkg::PW_AWAKE;
        end else if (take) begin
            unique case (i_cmd_op)
                ddrtc_pkg::OP_SREF_IN: pwr_q <= ddrtc_pkg::PW_SREF;
                ddrtc_pkg::OP_PD_IN: pwr_q <= ddrtc_pkg::PW_PD;
                ddrtc_pkg::OP_SREF_OUT, ddrtc_pkg::OP_PD_OUT: pwr_q <= ddrtc_pkg::PW_AWAKE;
                default: pwr_q <= pwr_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // refresh interval and posted debt
    // ------------------------------------------------------------
    logic refi_tick, ref_take;
    assign refi_tick = awake && (refi_q == '0);
    assign ref_take = take && (i_cmd_op == ddrtc_pkg::OP_REF);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            refi_q <= ddrtc_pkg::REFI_W'(REFI_COOL - 1);
        end else if (refi_tick) begin
            refi_q <= i_hot_temp ? ddrtc_pkg::REFI_W'(REFI_HOT - 1)
                                 : ddrtc_pkg::REFI_W'(REFI_COOL - 1);
        end else if (awake) begin
            refi_q <= refi_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            debt_q <= '0;
        end else if (refi_tick && !ref_take && debt_q < ddrtc_pkg::DEBT_W'(DMAX)) begin
            debt_q <= debt_q + 1'b1;
        end else if (ref_take && !refi_tick && debt_q != '0) begin
            debt_q <= debt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_refresh_due <= 1'b0;
            o_refresh_urgent <= 1'b0;
        end else begin
            o_refresh_due <= (debt_q != '0);
            o_refresh_urgent <= (debt_q == ddrtc_pkg::DEBT_W'(DMAX));
        end
    end

    // ------------------------------------------------------------
    // command pins
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_NOP;
            o_cke <= 1'b1;
            o_ba <= '0;
            o_a_ap <= 1'b0;
            o_cmd_ack <= 1'b0;
            op_q <= ddrtc_pkg::OP_NOP;
        end else begin
            o_cmd_ack <= take;
            op_q <= take ? i_cmd_op : ddrtc_pkg::OP_NOP;
            o_ba <= take ? i_cmd_bank : o_ba;
            o_a_ap <= take && i_cmd_ap;
            {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_NOP;
            if (take) begin
                unique case (i_cmd_op)
                    ddrtc_pkg::OP_ACT: {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_ACT;
                    ddrtc_pkg::OP_READ: {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_READ;
                    ddrtc_pkg::OP_WRITE: {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_WRITE;
                    ddrtc_pkg::OP_PRE: {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_PRE;
                    ddrtc_pkg::OP_REF, ddrtc_pkg::OP_SREF_IN:
                        {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_REF;
                    default: {o_ras_n, o_cas_n, o_we_n} <= ddrtc_pkg::PINS_NOP;
                endcase
                if (i_cmd_op == ddrtc_pkg::OP_SREF_IN || i_cmd_op == ddrtc_pkg::OP_PD_IN) begin
                    o_cke <= 1'b0;
                end else if (i_cmd_op == ddrtc_pkg::OP_SREF_OUT
                             || i_cmd_op == ddrtc_pkg::OP_PD_OUT) begin
                    o_cke <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // write strobe preamble
    // ------------------------------------------------------------
    logic wr_take;
    assign wr_take = take && (i_cmd_op == ddrtc_pkg::OP_WRITE);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_active_q <= 1'b0;
            o_dqs_oe <= 1'b0;
            o_dqs_o <= 1'b0;
        end else begin
            // a new write wins over the end of the previous one
            wr_active_q <= wr_take || (wr_active_q && !i_wdata_last);
            o_dqs_oe <= wr_take || (wr_active_q && !i_wdata_last);
            o_dqs_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [TW-1:0] since_act_q, since_ref_q, since_srx_q, since_wl_q;
    logic iss_act, iss_ref, iss_rd, iss_srx;
    assign iss_act = o_cmd_ack && (op_q == ddrtc_pkg::OP_ACT);
    assign iss_ref = o_cmd_ack && (op_q == ddrtc_pkg::OP_REF);
    assign iss_rd = o_cmd_ack && (op_q == ddrtc_pkg::OP_READ);
    assign iss_srx = o_cmd_ack && (op_q == ddrtc_pkg::OP_SREF_OUT);

    function automatic logic [TW-1:0] since_next(input logic ev, input logic [TW-1:0] c);
        return ev ? TW'(1) : ((c == ddrtc_pkg::SINCE_MAX) ? c : c + 1'b1);
    endfunction : since_next

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            since_act_q <= ddrtc_pkg::SINCE_MAX;
            since_ref_q <= ddrtc_pkg::SINCE_MAX;
            since_srx_q <= ddrtc_pkg::SINCE_MAX;
            since_wl_q <= ddrtc_pkg::SINCE_MAX;
        end else begin
            since_act_q <= since_next(iss_act, since_act_q);
            since_ref_q <= since_next(iss_ref, since_ref_q);
            since_srx_q <= since_next(iss_srx, since_srx_q);
            since_wl_q <= since_next(i_wdata_last, since_wl_q);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_act_to_ref: assert property (iss_ref |-> since_act_q >= TW'(RC))
        else $error("refresh too soon after activate");
    a_ref_to_next: assert property ((iss_ref || iss_act) |-> since_ref_q >= TW'(RFC))
        else $error("command too soon after refresh");
    a_act_to_rw: assert property (iss_act |=> !((op_q == ddrtc_pkg::OP_READ
        || op_q == ddrtc_pkg::OP_WRITE) && o_ba == $past(o_ba)))
        else $error("read or write too soon after activate");
    a_ap_write_bank: assert property ((o_cmd_ack && op_q == ddrtc_pkg::OP_WRITE && o_a_ap)
        |-> ##1 ap_pend_q[o_ba])
        else $error("autoprecharge write not held");
    a_act_gap: assert property (iss_act |-> since_act_q >= TW'(RRD))
        else $error("activates too close");
    a_wtr_gap: assert property (iss_rd |-> since_wl_q > TW'(WTR))
        else $error("read too soon after write data");
    a_srx_nonread: assert property ((o_cmd_ack && op_q != ddrtc_pkg::OP_READ
        && op_q != ddrtc_pkg::OP_NOP && !iss_srx) |-> since_srx_q >= TW'(XSNR))
        else $error("command too soon after self refresh exit");
    a_srx_read: assert property (iss_rd |-> since_srx_q >= TW'(XSRD))
        else $error("read too soon after self refresh exit");
    a_refi_debt: assert property ((refi_tick && !ref_take && debt_q < ddrtc_pkg::DEBT_W'(DMAX))
        |=> debt_q == $past(debt_q) + 1'b1)
        else $error("refresh interval not counted");
    a_debt_sat: assert property (debt_q <= ddrtc_pkg::DEBT_W'(DMAX))
        else $error("refresh debt above limit");
    a_pdx_read: assert property ((take && i_cmd_op == ddrtc_pkg::OP_PD_OUT && i_clk_unstable)
        |=> !rd_done [*8])
        else $error("read allowed after unstable power-down exit");
    a_dqs_pre: assert property ((o_cmd_ack && op_q == ddrtc_pkg::OP_WRITE
        && !$past(wr_active_q)) |-> o_dqs_oe && !o_dqs_o)
        else $error("write strobe preamble missing");

    c_act_rd: cover property (iss_act ##[1:10] iss_rd);
    c_srx_rd: cover property (iss_srx ##[200:400] iss_rd);
    c_urgent: cover property (o_refresh_urgent ##[1:20] iss_ref);

endmodule : ddrtc_ctrl

//--- logic/ddrtc_timer.sv
// module: loadable down counter that reports when a wait has elapsed
`timescale 1ns/1ps
module ddrtc_timer #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // load
    input wire logic i_load,
    input wire logic [W-1:0] i_value,
    // status
    output logic o_done
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
        end else if (i_load) begin
            cnt_q <= i_value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign o_done = (cnt_q == '0);

endmodule : ddrtc_timer
